// >>> design/hpr_pkg.sv
// shared sizes, state encoding and reset values for the host port block
package hpr_pkg;

  localparam int ADDR_W   = 15; // host address lines, bit 0 is lsb
  localparam int DATA_W   = 16; // host data lines, bit 0 is lsb
  localparam int STREAM_N = 32; // serial outputs per port

  // host strobe level meaning
  localparam logic RW_READ  = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // synchroniser idle values (strobes idle high)
  localparam logic [1:0] SYNC_IDLE_HI = 2'b11;
  localparam logic [1:0] SYNC_IDLE_LO = 2'b00;

  // serial output parking level during reset
  localparam logic [STREAM_N-1:0] SER_PARK_LEVEL = {STREAM_N{1'b1}};

  typedef enum logic [1:0] {
    HPR_IDLE,
    HPR_WAIT,
    HPR_ACK
  } hpr_state_e;

endpackage

// >>> design/hpr_reset_sync.sv
// reset conditioner: asynchronous apply, synchronous release of the device reset pin
`timescale 1ns/1ps
module hpr_reset_sync
  import hpr_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic dev_reset_n_i,
  output logic      dev_rst_o
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } hpr_rs_s;

  hpr_rs_s cur;
  hpr_rs_s next_cur;

  // release walks through two stages before reaching the core
  always_comb
  begin
    next_cur.stage1 = 1'b0;
    next_cur.stage2 = cur.stage1;
    if (rst_i)
    begin
      next_cur.stage1 = 1'b1;
      next_cur.stage2 = 1'b1;
    end
  end

  // pin low sets both stages at once, no clock needed
  always_ff @(posedge ref_clk_i or negedge dev_reset_n_i)
  begin
    if (!dev_reset_n_i)
      cur <= '1;
    else
      cur <= next_cur;
  end

  assign dev_rst_o = cur.stage2;

endmodule

// >>> design/hpr_host_port.sv
// asynchronous strobe host port with device reset and serial output parking
// Operation
// - access only while strobe and select low
// - drive data on reads, sample on writes
// - acknowledge pulled low, else three-stated
// - reset applies on next clock, releases on clock
// - reset parks serial outputs per strap
// - reset clears sequencer and core registers
// - 15-bit address selects internal locations
// - 16-bit data bus, bit zero lsb
// - strap low: always active; high: follow enables
`timescale 1ns/1ps
module hpr_host_port
  import hpr_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                dev_reset_n_i,
  input  wire logic                chip_select_n_i,
  input  wire logic                data_strobe_n_i,
  input  wire logic                read_write_i,
  input  wire logic [ADDR_W-1:0]   host_address_bus_i,
  input  wire logic [DATA_W-1:0]   host_data_bus_i,
  output logic      [DATA_W-1:0]   host_data_bus_o,
  output logic                     host_data_bus_oe_o,
  output logic                     transfer_ack_n_o,
  output logic                     transfer_ack_n_oe_o,
  input  wire logic                local_out_idle_sel_i,
  input  wire logic                backplane_out_idle_sel_i,
  input  wire logic [STREAM_N-1:0] local_serial_data_i,
  input  wire logic [STREAM_N-1:0] local_serial_en_i,
  input  wire logic [STREAM_N-1:0] backplane_serial_data_i,
  input  wire logic [STREAM_N-1:0] backplane_serial_en_i,
  output logic      [STREAM_N-1:0] local_serial_outputs_o,
  output logic      [STREAM_N-1:0] local_serial_oe_o,
  output logic      [STREAM_N-1:0] backplane_serial_outputs_o,
  output logic      [STREAM_N-1:0] backplane_serial_oe_o,
  output logic                     core_req_o,
  output logic                     core_we_o,
  output logic      [ADDR_W-1:0]   core_addr_o,
  output logic      [DATA_W-1:0]   core_wdata_o,
  input  wire logic [DATA_W-1:0]   core_rdata_i,
  input  wire logic                core_done_i,
  output logic                     core_reset_o
);

  typedef struct packed {
    hpr_state_e          st;
    logic [1:0]          cs_n_q;
    logic [1:0]          ds_n_q;
    logic [1:0]          rw_q;
    logic [ADDR_W-1:0]   addr_q1;
    logic [ADDR_W-1:0]   addr_q2;
    logic [DATA_W-1:0]   din_q1;
    logic [DATA_W-1:0]   din_q2;
    logic [1:0]          lsel_q;
    logic [1:0]          bsel_q;
    logic                lsel_held;
    logic                bsel_held;
    logic                is_read;
    logic [DATA_W-1:0]   dout;
    logic                dout_oe;
    logic                ack_oe;
    logic                ack_n;
    logic                req;
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                core_rst;
    logic [STREAM_N-1:0] lso;
    logic [STREAM_N-1:0] lsoe;
    logic [STREAM_N-1:0] bso;
    logic [STREAM_N-1:0] bsoe;
  } hpr_st_s;

  hpr_st_s cur;
  hpr_st_s next_cur;
  logic    dev_rst;
  logic    rst_all;
  logic    act;

  // device reset pin conditioning
  hpr_reset_sync u_reset_sync (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .dev_reset_n_i (dev_reset_n_i),
    .dev_rst_o     (dev_rst)
  );

  // serial output level and enable after reset, from held strap
  function automatic logic [2*STREAM_N-1:0] ser_drive(
    input logic                strap,
    input logic [STREAM_N-1:0] data,
    input logic [STREAM_N-1:0] en
  );
    logic [STREAM_N-1:0] oe;
    oe = strap ? en : {STREAM_N{1'b1}};
    return {data, oe};
  endfunction

  assign rst_all = rst_i | dev_rst;
  // access window seen through synchronisers
  assign act = !cur.cs_n_q[1] && !cur.ds_n_q[1];

  // next state: synchronisers, access sequencer, output parking
  always_comb
  begin
    next_cur = cur;
    next_cur.cs_n_q  = {cur.cs_n_q[0], chip_select_n_i};
    next_cur.ds_n_q  = {cur.ds_n_q[0], data_strobe_n_i};
    next_cur.rw_q    = {cur.rw_q[0], read_write_i};
    next_cur.addr_q1 = host_address_bus_i;
    next_cur.addr_q2 = cur.addr_q1;
    next_cur.din_q1  = host_data_bus_i;
    next_cur.din_q2  = cur.din_q1;
    next_cur.lsel_q  = {cur.lsel_q[0], local_out_idle_sel_i};
    next_cur.bsel_q  = {cur.bsel_q[0], backplane_out_idle_sel_i};
    next_cur.req      = 1'b0;
    next_cur.core_rst = 1'b0;
    {next_cur.lso, next_cur.lsoe} =
      ser_drive(cur.lsel_held, local_serial_data_i, local_serial_en_i);
    {next_cur.bso, next_cur.bsoe} =
      ser_drive(cur.bsel_held, backplane_serial_data_i, backplane_serial_en_i);
    case (cur.st)
      HPR_IDLE:
      begin
        if (act)
        begin
          next_cur.req     = 1'b1;
          next_cur.is_read = (cur.rw_q[1] == RW_READ);
          next_cur.we      = (cur.rw_q[1] == RW_WRITE);
          next_cur.addr    = cur.addr_q2;
          next_cur.wdata   = cur.din_q2;
          next_cur.st      = HPR_WAIT;
        end
      end
      HPR_WAIT:
      begin
        if (core_done_i)
        begin
          if (act)
          begin
            next_cur.ack_oe = 1'b1;
            next_cur.st     = HPR_ACK;
            if (cur.is_read)
            begin
              next_cur.dout    = core_rdata_i;
              next_cur.dout_oe = 1'b1;
            end
          end
          else
            next_cur.st = HPR_IDLE; // host gave up, no acknowledge
        end
      end
      HPR_ACK:
      begin
        if (!act)
        begin
          next_cur.ack_oe  = 1'b0;
          next_cur.dout_oe = 1'b0;
          next_cur.st      = HPR_IDLE;
        end
      end
      default:
      begin
        next_cur.st = HPR_IDLE;
      end
    endcase
    // reset: clear state, keep strap capture running; rst_i also idles the strobe synchronisers
    if (rst_all)
    begin
      next_cur.st        = HPR_IDLE;
      next_cur.is_read   = 1'b0;
      next_cur.dout      = '0;
      next_cur.dout_oe   = 1'b0;
      next_cur.ack_oe    = 1'b0;
      next_cur.req       = 1'b0;
      next_cur.we        = 1'b0;
      next_cur.addr      = '0;
      next_cur.wdata     = '0;
      next_cur.core_rst  = 1'b1;
      next_cur.lsel_held = cur.lsel_q[1];
      next_cur.bsel_held = cur.bsel_q[1];
      next_cur.lso       = SER_PARK_LEVEL;
      next_cur.lsoe      = {STREAM_N{~cur.lsel_q[1]}};
      next_cur.bso       = SER_PARK_LEVEL;
      next_cur.bsoe      = {STREAM_N{~cur.bsel_q[1]}};
      if (rst_i)
      begin
        next_cur.cs_n_q = SYNC_IDLE_HI;
        next_cur.ds_n_q = SYNC_IDLE_HI;
        next_cur.rw_q   = SYNC_IDLE_LO;
      end
    end
    next_cur.ack_n = !next_cur.ack_oe;
  end

  // single state register
  always_ff @(posedge ref_clk_i)
  begin
    cur <= next_cur;
  end

  // outputs straight from the state register
  assign host_data_bus_o            = cur.dout;
  assign host_data_bus_oe_o         = cur.dout_oe;
  assign transfer_ack_n_o           = cur.ack_n;
  assign transfer_ack_n_oe_o        = cur.ack_oe;
  assign local_serial_outputs_o     = cur.lso;
  assign local_serial_oe_o          = cur.lsoe;
  assign backplane_serial_outputs_o = cur.bso;
  assign backplane_serial_oe_o      = cur.bsoe;
  assign core_req_o                 = cur.req;
  assign core_we_o                  = cur.we;
  assign core_addr_o                = cur.addr;
  assign core_wdata_o               = cur.wdata;
  assign core_reset_o               = cur.core_rst;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_all);

  // port guards
  idle_ignores_bus_a: assert property (
    (cur.st == HPR_IDLE) && cur.cs_n_q[1] |=> !core_req_o)
    else $error("request raised while chip select high");
  req_needs_both_a: assert property (
    $rose(core_req_o) |-> $past(!cur.cs_n_q[1] && !cur.ds_n_q[1]))
    else $error("request without both strobes low");
  read_drive_only_a: assert property (
    host_data_bus_oe_o |-> transfer_ack_n_oe_o && cur.is_read)
    else $error("data bus driven outside read acknowledge");
  write_no_drive_a: assert property (
    core_req_o && core_we_o |-> !host_data_bus_oe_o ##1 !host_data_bus_oe_o)
    else $error("data bus driven during write");
  dir_sense_a: assert property (
    $rose(core_req_o) |-> core_we_o == ($past(cur.rw_q[1]) == RW_WRITE))
    else $error("read/write sense wrong");
  addr_pass_a: assert property (
    $rose(core_req_o) |-> core_addr_o == $past(cur.addr_q2))
    else $error("address not taken from synchronised bus");
  ack_low_only_a: assert property (
    transfer_ack_n_oe_o |-> !transfer_ack_n_o)
    else $error("acknowledge driven high");
  ack_on_done_a: assert property (
    (cur.st == HPR_WAIT) && core_done_i && act |=> transfer_ack_n_oe_o)
    else $error("acknowledge missing after completion");
  ack_hold_a: assert property (
    transfer_ack_n_oe_o && act |=> transfer_ack_n_oe_o)
    else $error("acknowledge dropped while strobes held");
  ack_release_a: assert property (
    transfer_ack_n_oe_o && !act |=> !transfer_ack_n_oe_o && !host_data_bus_oe_o)
    else $error("acknowledge not released");
  reset_park_a: assert property (disable iff (1'b0)
    rst_all && $past(rst_all, 2) |=> local_serial_outputs_o == SER_PARK_LEVEL
      && local_serial_oe_o == {STREAM_N{~$past(cur.lsel_q[1])}}
      && backplane_serial_oe_o == {STREAM_N{~$past(cur.bsel_q[1])}})
    else $error("serial outputs not parked in reset");
  reset_clear_a: assert property (disable iff (1'b0)
    rst_all |=> core_reset_o && !transfer_ack_n_oe_o && !core_req_o)
    else $error("reset did not clear port");
  strap_low_active_a: assert property (
    !rst_all && !cur.lsel_held |=> local_serial_oe_o == {STREAM_N{1'b1}})
    else $error("local outputs not active with strap low");

  read_seen_c: cover property (core_req_o && !core_we_o ##[1:20] host_data_bus_oe_o);
  write_seen_c: cover property (core_req_o && core_we_o ##[1:20] transfer_ack_n_oe_o);
  abort_seen_c: cover property ((cur.st == HPR_WAIT) && core_done_i && !act);

endmodule

// >>> tb/hpr_host_model.sv
// host processor model: strobe bus master keeping the turnaround gap
`timescale 1ns/1ps
module hpr_host_model
  import hpr_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              ack_oe_i,
  input  wire logic              data_oe_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic                   cs_n_o,
  output logic                   ds_n_o,
  output logic                   rw_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] data_o
);
  // idle bus at time zero
  initial
  begin
    cs_n_o = 1'b1;
    ds_n_o = 1'b1;
    rw_o   = RW_READ;
    addr_o = '0;
    data_o = '0;
  end

  // raw strobe levels, for refusal cases
  task set_strobes(input logic cs, input logic ds);
    @(posedge ref_clk_i);
    #1;
    cs_n_o = cs;
    ds_n_o = ds;
  endtask

  // one full access; hold keeps strobes low after the ack
  task access(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
              input int hold, output logic [DATA_W-1:0] rdat, output logic acked,
              output logic oe, output int rel);
    int n;
    @(posedge ref_clk_i);
    #1;
    rw_o   = rd;
    addr_o = a;
    data_o = rd ? ~data_o : wd;
    repeat (2) @(posedge ref_clk_i);
    #1;
    cs_n_o = 1'b0;
    ds_n_o = 1'b0;
    acked  = 1'b0;
    n      = 0;
    while (!acked && n < 40)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
      acked = (ack_oe_i === 1'b1);
    end
    rdat = data_i;
    oe   = data_oe_i;
    repeat (hold) @(posedge ref_clk_i);
    #1;
    acked  = acked && (ack_oe_i === 1'b1);
    cs_n_o = 1'b1;
    ds_n_o = 1'b1;
    addr_o = ~a;
    rel    = 0;
    while (ack_oe_i !== 1'b0 && rel < 10)
    begin
      @(posedge ref_clk_i);
      #1;
      rel++;
    end
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule

// >>> tb/test_async_host_port_with_reset.sv
// testbench for the host port: host model, core stub and scenarios
`timescale 1ns/1ps
module test_async_host_port_with_reset;
  import hpr_pkg::*;
  logic                ref_clk_i, rst_i, dev_reset_n_i, lsel, bsel;
  logic [STREAM_N-1:0] lsd, lse, bsd, bse;
  logic [STREAM_N-1:0] lso, lsoe, bso, bsoe;
  logic                cs_n, ds_n, rw, doe, ack_n, ack_oe, creq, cwe, cdone, crst, r_we;
  logic [ADDR_W-1:0]   addr, caddr, r_addr;
  logic [DATA_W-1:0]   hd, dout, cwd, crd, r_wd, bus_in;
  int                  mismatches, n_checks, n_req, cnt, core_lat;
  logic                ack_low;

  // acknowledge line as the host sees it, pull-up when floated
  assign ack_low = (ack_oe ? ack_n : 1'b1) == 1'b0;

  // data wire resolved from both drivers
  assign bus_in = doe ? dout : hd;

  hpr_host_port i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dev_reset_n_i(dev_reset_n_i),
    .chip_select_n_i(cs_n), .data_strobe_n_i(ds_n), .read_write_i(rw),
    .host_address_bus_i(addr), .host_data_bus_i(bus_in), .host_data_bus_o(dout),
    .host_data_bus_oe_o(doe), .transfer_ack_n_o(ack_n), .transfer_ack_n_oe_o(ack_oe),
    .local_out_idle_sel_i(lsel), .backplane_out_idle_sel_i(bsel),
    .local_serial_data_i(lsd), .local_serial_en_i(lse), .backplane_serial_data_i(bsd),
    .backplane_serial_en_i(bse), .local_serial_outputs_o(lso), .local_serial_oe_o(lsoe),
    .backplane_serial_outputs_o(bso), .backplane_serial_oe_o(bsoe), .core_req_o(creq),
    .core_we_o(cwe), .core_addr_o(caddr), .core_wdata_o(cwd), .core_rdata_i(crd),
    .core_done_i(cdone), .core_reset_o(crst));

  hpr_host_model i_host (.ref_clk_i(ref_clk_i), .ack_oe_i(ack_low), .data_oe_i(doe),
    .data_i(dout), .cs_n_o(cs_n), .ds_n_o(ds_n), .rw_o(rw), .addr_o(addr), .data_o(hd));

  // clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // core stub: answers each request after core_lat cycles
  always @(posedge ref_clk_i)
  begin
    #1;
    cdone = 1'b0;
    if (creq === 1'b1)
    begin
      n_req++;
      r_we   = cwe;
      r_addr = caddr;
      r_wd   = cwd;
      cnt    = core_lat;
    end
    if (cnt > 0)
    begin
      cnt--;
      cdone = (cnt == 0);
      crd   = {1'b1, r_addr};
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task report_and_stop;
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // write, read with slow core, held strobes
  task t_access(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                input int lat, input int hold);
    logic [DATA_W-1:0] rdat;
    logic              ak, oe;
    int                rel;
    core_lat = lat;
    n_req    = 0;
    i_host.access(rd, a, wd, hold, rdat, ak, oe, rel);
    chk("ack", 1, ak);
    chk("ack_release", 1, rel <= 3);
    chk("req_count", 1, n_req);
    chk("core_we", rd == RW_WRITE, r_we);
    chk("core_addr", a, r_addr);
    chk("data_oe", rd == RW_READ, oe);
    if (rd == RW_READ)
      chk("read_data", {1'b1, a}, rdat);
    else
      chk("core_wdata", wd, r_wd);
  endtask

  // strobe without chip select must be ignored
  task t_cs_high;
    n_req = 0;
    i_host.set_strobes(1'b1, 1'b0);
    repeat (10) @(posedge ref_clk_i);
    #1;
    chk("req_no_cs", 0, n_req);
    chk("ack_no_cs", 0, ack_oe);
    i_host.set_strobes(1'b1, 1'b1);
  endtask

  // host drops strobes before the core answers: no acknowledge
  task t_abort;
    int seen;
    seen     = 0;
    core_lat = 12;
    n_req    = 0;
    i_host.set_strobes(1'b0, 1'b0);
    repeat (4) @(posedge ref_clk_i);
    i_host.set_strobes(1'b1, 1'b1);
    repeat (20)
    begin
      @(posedge ref_clk_i);
      #1;
      if (ack_oe !== 1'b0)
        seen++;
    end
    chk("abort_req", 1, n_req);
    chk("abort_ack", 0, seen);
  endtask

  // device reset with given strap levels
  task t_reset(input logic ls, input logic bs);
    @(posedge ref_clk_i);
    #1;
    lsel          = ls;
    bsel          = bs;
    repeat (3) @(posedge ref_clk_i); // straps settle through synchronisers
    #1;
    dev_reset_n_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("reset_apply", 1, crst);
    chk("local_park", {STREAM_N{1'b1}}, lso);
    chk("local_oe_rst", {STREAM_N{~ls}}, lsoe);
    chk("bp_park", {STREAM_N{1'b1}}, bso);
    chk("bp_oe_rst", {STREAM_N{~bs}}, bsoe);
    chk("ack_oe_rst", 0, ack_oe);
    dev_reset_n_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("reset_hold", 1, crst);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("reset_release", 0, crst);
    chk("local_run", lsd, lso);
    chk("bp_run", bsd, bso);
    chk("local_oe_run", ls ? lse : {STREAM_N{1'b1}}, lsoe);
    chk("bp_oe_run", bs ? bse : {STREAM_N{1'b1}}, bsoe);
  endtask

  // watchdog
  initial
  begin
    #20000;
    mismatches++;
    report_and_stop;
  end

  // main sequence
  initial
  begin
    mismatches    = 0;
    n_checks      = 0;
    n_req         = 0;
    cnt           = 0;
    core_lat      = 1;
    rst_i         = 1'b1;
    dev_reset_n_i = 1'b1;
    lsel          = 1'b0;
    bsel          = 1'b1;
    lsd           = 32'h1234abcd;
    lse           = 32'h0f0f00ff;
    bsd           = 32'hc0ffee11;
    bse           = 32'h00ff0f0f;
    cdone         = 1'b0;
    crd           = 16'h0000;
    repeat (5) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    t_access(RW_WRITE, 15'h7fff, 16'ha55a, 1, 0);
    t_access(RW_READ, 15'h0001, 16'h0000, 6, 0);
    t_access(RW_READ, 15'h2aaa, 16'h0000, 2, 10);
    t_access(RW_WRITE, 15'h0000, 16'h0001, 1, 0);
    t_cs_high();
    t_abort();
    for (int i = 0; i < 4; i++)
      t_reset(i[0], i[1]);
    t_access(RW_READ, 15'h4000, 16'h0000, 1, 0);
    report_and_stop;
  end
endmodule
